// >>> rtl/tcfpm_map.vh
// constants for the two-counter frequency and period meter
// assumes a 25 MHz REF_CLK and an input already synchronous to it
//
// Overview of operation
// - in high-frequency mode the companion counter emits a gate pulse train whose period is the gate duration.
// - in high-frequency mode the measuring counter counts input periods inside each gate and offers the count.
// - in high-frequency mode period equals gate duration over the counted periods, left to software.
// - in high-frequency mode frequency equals the counted periods over gate duration, left to software.
// - in large-range mode the companion counter divides the input frequency by the divisor.
// - in large-range mode the divided signal period is measured in timebase ticks.
// - in large-range mode period equals the measured period over the divisor, left to software.
// - in large-range mode frequency equals the divisor over the measured period, left to software.
// - a larger divisor shifts the measurable range upward in proportion.
// - large-range mode accepts inputs faster than the 100 kHz timebase, up to half the REF_CLK rate.
// - the timebase is selectable between 20 MHz and 100 kHz.
`ifndef TCFPM_MAP_VH
`define TCFPM_MAP_VH
`define TCFPM_CNT_W        24
`define TCFPM_MODE_HF      1'b0
`define TCFPM_MODE_LR      1'b1
`define TCFPM_CLK_HZ       25000000
`define TCFPM_TB_FAST_HZ   20000000
`define TCFPM_TB_SLOW_HZ   100000
`define TCFPM_ACC_W        25
`define TCFPM_INC_FAST     25'H1312D00
`define TCFPM_INC_SLOW     25'H00186A0
`define TCFPM_INC_CLK      25'H17D7840
`define TCFPM_CNT_ONE      24'H000001
`define TCFPM_CNT_ZERO     24'H000000
`endif

// >>> rtl/tcfpm_meter.v
// two-counter frequency and period meter core
// assumes SIG_IN synchronous to REF_CLK; software reads results and scales them
`timescale 1ns/10ps
`include "tcfpm_map.vh"
module tcfpm_meter
(
  input  wire                    REF_CLK,
  input  wire                    RST,
  input  wire                    MODE,
  input  wire                    TB_SEL,
  input  wire [`TCFPM_CNT_W-1:0] GATE_TICKS,
  input  wire [`TCFPM_CNT_W-1:0] DIVISOR,
  input  wire                    SIG_IN,
  output reg  [`TCFPM_CNT_W-1:0] RESULT,
  output reg                     RESULT_VALID,
  output reg                     OVERFLOW,
  output reg                     GATE_OUT,
  output reg                     DIV_OUT
);

  // ************************************************************
  // timebase: fractional accumulator gives 20 MHz or 100 kHz ticks
  // ************************************************************

  // the accumulator adds the wanted rate each clock and wraps at the
  // clock rate, so ticks come evenly spread without a divider chain
  reg  [`TCFPM_ACC_W-1:0] acc_r;
  reg  [`TCFPM_ACC_W-1:0] acc_nxt;
  reg  [`TCFPM_ACC_W-1:0] acc_inc;
  reg  [`TCFPM_ACC_W:0]   acc_sum;
  reg  [`TCFPM_ACC_W:0]   acc_red;
  reg                     tb_tick;

  always @*
  begin
    acc_inc = TB_SEL ? `TCFPM_INC_SLOW : `TCFPM_INC_FAST;
    acc_sum = {1'b0, acc_r} + {1'b0, acc_inc};
    acc_red = acc_sum - {1'b0, `TCFPM_INC_CLK};
    tb_tick = (acc_sum >= {1'b0, `TCFPM_INC_CLK});
    if (tb_tick)
      acc_nxt = acc_red[`TCFPM_ACC_W-1:0];
    else
      acc_nxt = acc_sum[`TCFPM_ACC_W-1:0];
  end

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      acc_r <= {`TCFPM_ACC_W{1'b0}};
    else
      acc_r <= acc_nxt;
  end

  // ************************************************************
  // input edge detect
  // ************************************************************

  // the delayed copy resets low, the idle level of the input
  reg                     sig_d_r;
  reg                     sig_rise;

  always @*
  begin
    sig_rise = SIG_IN & ~sig_d_r;
  end

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      sig_d_r <= 1'b0;
    else
      sig_d_r <= SIG_IN;
  end

  // ************************************************************
  // companion counter: gate generator or input divider
  // ************************************************************

  // in high-frequency mode it counts timebase ticks into gates,
  // in large-range mode it counts input edges into divided periods
  reg  [`TCFPM_CNT_W-1:0] comp_r;
  reg  [`TCFPM_CNT_W-1:0] comp_nxt;
  reg  [`TCFPM_CNT_W-1:0] comp_lim;
  reg  [`TCFPM_CNT_W-1:0] comp_inc;
  reg                     comp_ev;
  reg                     comp_end;
  reg                     gate_nxt;
  reg                     div_nxt;

  always @*
  begin
    if (MODE == `TCFPM_MODE_HF)
    begin
      comp_lim = GATE_TICKS;
      comp_ev  = tb_tick;
    end
    else
    begin
      comp_lim = DIVISOR;
      comp_ev  = sig_rise;
    end
    comp_inc = comp_r + `TCFPM_CNT_ONE;
    comp_end = comp_ev && (comp_inc >= comp_lim);
    if (comp_end)
      comp_nxt = `TCFPM_CNT_ZERO;
    else if (comp_ev)
      comp_nxt = comp_inc;
    else
      comp_nxt = comp_r;
    gate_nxt = (MODE == `TCFPM_MODE_HF) && comp_end;
    div_nxt  = (MODE == `TCFPM_MODE_LR) && comp_end;
  end

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      comp_r <= `TCFPM_CNT_ZERO;
    else
      comp_r <= comp_nxt;
  end

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      GATE_OUT <= 1'b0;
      DIV_OUT  <= 1'b0;
    end
    else
    begin
      GATE_OUT <= gate_nxt;
      DIV_OUT  <= div_nxt;
    end
  end

  // ************************************************************
  // measuring counter: window boundary and next values
  // ************************************************************

  // an event in the boundary cycle already belongs to the new window,
  // so the counter restarts at one rather than at zero then
  reg  [`TCFPM_CNT_W-1:0] meas_r;
  reg  [`TCFPM_CNT_W-1:0] meas_nxt;
  reg  [`TCFPM_CNT_W-1:0] meas_inc;
  reg                     wrap_r;
  reg                     wrap_nxt;
  reg                     armed_r;
  reg                     armed_nxt;
  reg                     meas_ev;
  reg                     bound;
  reg                     meas_wrap;

  always @*
  begin
    if (MODE == `TCFPM_MODE_HF)
    begin
      meas_ev = sig_rise;
      bound   = GATE_OUT;
    end
    else
    begin
      meas_ev = tb_tick;
      bound   = DIV_OUT;
    end
    meas_inc  = meas_r + `TCFPM_CNT_ONE;
    meas_wrap = meas_ev && (&meas_r);
    if (bound)
    begin
      meas_nxt  = meas_ev ? `TCFPM_CNT_ONE : `TCFPM_CNT_ZERO;
      wrap_nxt  = 1'b0;
      armed_nxt = 1'b1;
    end
    else
    begin
      meas_nxt  = meas_ev ? meas_inc : meas_r;
      wrap_nxt  = wrap_r | meas_wrap;
      armed_nxt = armed_r;
    end
  end

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      meas_r  <= `TCFPM_CNT_ZERO;
      wrap_r  <= 1'b0;
      armed_r <= 1'b0;
    end
    else
    begin
      meas_r  <= meas_nxt;
      wrap_r  <= wrap_nxt;
      armed_r <= armed_nxt;
    end
  end

  // ************************************************************
  // result registers
  // ************************************************************

  // the first window after reset is partial and is never reported;
  // scaling into seconds or hertz is left to software
  reg  [`TCFPM_CNT_W-1:0] result_nxt;
  reg                     valid_nxt;
  reg                     ovf_nxt;

  always @*
  begin
    result_nxt = RESULT;
    valid_nxt  = 1'b0;
    ovf_nxt    = OVERFLOW;
    if (bound && armed_r)
    begin
      result_nxt = meas_r;
      valid_nxt  = 1'b1;
      ovf_nxt    = wrap_r | meas_wrap;
    end
  end

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      RESULT       <= `TCFPM_CNT_ZERO;
      RESULT_VALID <= 1'b0;
      OVERFLOW     <= 1'b0;
    end
    else
    begin
      RESULT       <= result_nxt;
      RESULT_VALID <= valid_nxt;
      OVERFLOW     <= ovf_nxt;
    end
  end

endmodule // tcfpm_meter

// >>> testbench/tcfpm_src.sv
// partner: periodic input source
// assumes the bench clock
`timescale 1ns/10ps
module tcfpm_src(
  input wire       CLK,
  input wire [7:0] PER,
  output reg       SIG
);
  reg [7:0] n_r = 8'H00;
  always @(posedge CLK)
  begin
    n_r <= (n_r + 8'H01 >= PER) ? 8'H00 : n_r + 8'H01;
    SIG <= (n_r == 8'H00);
  end
endmodule // tcfpm_src

// >>> testbench/tcfpm_chk_asserts.sv
// checker: port timing of the meter
// assumes bind onto tcfpm_meter
`timescale 1ns/10ps
module tcfpm_chk(
  input wire        REF_CLK,
  input wire        RST,
  input wire        MODE,
  input wire [23:0] GATE_TICKS,
  input wire [23:0] DIVISOR,
  input wire [23:0] RESULT,
  input wire        RESULT_VALID,
  input wire        OVERFLOW,
  input wire        GATE_OUT,
  input wire        DIV_OUT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  valid_cause_a: assert property (RESULT_VALID |-> $past(GATE_OUT || DIV_OUT)) else $error("bad valid");
  valid_pulse_a: assert property (RESULT_VALID |=> !RESULT_VALID) else $error("long valid");
  result_hold_a: assert property (!RESULT_VALID |-> $stable(RESULT)) else $error("result moved");
  ovf_hold_a: assert property (!RESULT_VALID |-> $stable(OVERFLOW)) else $error("ovf moved");
  gate_pulse_a: assert property (GATE_OUT && GATE_TICKS > 2 |=> !GATE_OUT) else $error("long gate");
  div_gap_a: assert property (DIV_OUT && DIVISOR > 1 |=> !DIV_OUT[*2]) else $error("div gap");
  lr_gate_a: assert property (MODE && $past(MODE) |-> !GATE_OUT) else $error("gate in lr");
  hf_div_a: assert property (!MODE && $past(!MODE) |-> !DIV_OUT) else $error("div in hf");
endmodule // tcfpm_chk
bind tcfpm_meter tcfpm_chk tcfpm_chk_i(.*);

// >>> testbench/two_counter_freq_period_meter_tb_top.sv
// bench: six random gate and divisor runs, then two fixed slow-timebase runs
// assumes a 5-clock input period
`timescale 1ns/10ps
module two_counter_freq_period_meter_tb_top;
  reg clk = 0, rst = 1, mode = 0, tbs = 0;
  reg [23:0] gt = 24'H8, dv = 24'H2, dt;
  reg [31:0] s = 32'H86F5EEF2;
  wire [23:0] res;
  wire sig, rv, ov, go, dq;
  integer mismatches = 0, n_compared = 0, k, t0;
  initial forever #20 clk = ~clk;
  tcfpm_src tcfpm_src_i(.CLK(clk), .PER(8'H05), .SIG(sig));
  tcfpm_meter tcfpm_meter_i(.REF_CLK(clk), .RST(rst), .MODE(mode), .TB_SEL(tbs), .GATE_TICKS(gt),
    .DIVISOR(dv), .SIG_IN(sig), .RESULT(res), .RESULT_VALID(rv), .OVERFLOW(ov), .GATE_OUT(go), .DIV_OUT(dq));
  function [31:0] xs(input [31:0] a);
    reg [31:0] b;
    begin
      b = a ^ (a << 13);
      b = b ^ (b >> 17);
      xs = b ^ (b << 5);
    end
  endfunction
  // source edge every 5 clocks; fast timebase 4 ticks per 5 clocks, slow 1 per 250
  function [23:0] exp_res(input m, input t, input [23:0] g, input [23:0] d);
    begin
      if (m)
        exp_res = t ? d / 24'H32 : d * 24'H4;
      else
        exp_res = t ? g * 24'H32 : g / 24'H4;
    end
  endfunction
  function [23:0] exp_per(input m, input t, input [23:0] g, input [23:0] d);
    begin
      if (m)
        exp_per = d * 24'H5;
      else
        exp_per = t ? g * 24'HFA : g / 24'H4 * 24'H5;
    end
  endfunction
  task cmp(input [63:0] nm, input [23:0] e, input [23:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e)
      begin
        mismatches = mismatches + 1;
        $display("MISMATCH %0s exp %0d got %0d", nm, e, g);
      end
    end
  endtask
  task cmp_bit(input [63:0] nm, input e, input g);
    begin
      n_compared = n_compared + 1;
      if (g !== e)
      begin
        mismatches = mismatches + 1;
        $display("MISMATCH %0s exp %0b got %0b", nm, e, g);
      end
    end
  endtask
  task conclude;
    begin
      $display("mismatches %0d n_compared %0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial
  begin
    #2000000;
    mismatches = mismatches + 1;
    conclude;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    for (k = 0; k < 8; k = k + 1)
    begin
      s = xs(s);
      mode = k[0];
      tbs = (k > 5);
      gt = (k > 5) ? 24'H2 : {17'H0, s[4:0], 2'b00} + 24'H8;
      dv = (k > 5) ? 24'H64 : {19'H0, s[12:8]} + 24'H2;
      repeat (3) @(posedge rv);
      #1 cmp("result", exp_res(mode, tbs, gt, dv), res);
      cmp_bit("overflow", 1'b0, ov);
      @(posedge (mode ? dq : go)) t0 = $time;
      @(posedge (mode ? dq : go)) dt = ($time - t0) / 40;
      cmp("period", exp_per(mode, tbs, gt, dv), dt);
      @(posedge clk);
      #1;
    end
    conclude;
  end
endmodule // two_counter_freq_period_meter_tb_top
